// *** src/ldm_core.v ***
// Load and move decode/execute unit of a 32-bit soft processor.
// Assumes an external register file read combinationally by the
// index fields of INSTR_IN, a data master with wait and read-valid,
// and an optional data cache answering a lookup in the same cycle.
`include "ldm_regs.vh"
`timescale 1ns/1ns

// Overview of operation
// (RULE1) Opcodes 0x03/0x23: unsigned byte load
// (RULE2) Byte load zero-extends into second register
// (RULE3) Address is base plus sign-extended offset
// (RULE4) Signed halfword load sign-extends to 32
// (RULE5) Unsigned halfword load clears upper 16
// (RULE6) Software keeps halfword addresses even
// (RULE7) Software keeps word addresses word aligned
// (RULE8) Word load writes word unchanged
// (RULE9) Cached loads may answer from cache
// (RULE10) I/O loads bypass cache, always bus read
// (RULE11) Without cache, I/O equals cached load
// (RULE12) Opcodes 0x0f/0x2f: signed halfword load
// (RULE13) Opcodes 0x0b/0x2b: unsigned halfword load
// (RULE14) Opcodes 0x17/0x37: word load
// (RULE15) Loads carry base, destination, signed offset
// (RULE16) High constant load: literal high, zeros low
// (RULE17) Small constant: sign-extended add to zero
// (RULE18) Register copy: add with zero register
// (RULE19) Assembler builds addresses with high/low pair
// (RULE20) Field layout: A, B, immediate, opcode
module ldm_core #(
  parameter       HAS_DCACHE = 1,
  parameter [5:0] OP_ADDI    = `LDM_OP_ADDI_DEF,
  parameter [5:0] OP_ORI     = `LDM_OP_ORI_DEF,
  parameter [5:0] OP_ORHI    = `LDM_OP_ORHI_DEF,
  parameter [5:0] OP_RTYPE   = `LDM_OP_RTYPE_DEF,
  parameter [5:0] OPX_ADD    = `LDM_OPX_ADD_DEF
) (
  input  wire        CORE_CLK_IN,
  input  wire        SRST_IN,
  input  wire [31:0] INSTR_IN,
  input  wire        INSTR_VALID_IN,
  input  wire [31:0] SRC_A_DATA_IN,
  input  wire [31:0] SRC_B_DATA_IN,
  output reg         INSTR_READY_OUT,
  output reg         UNHANDLED_OUT,
  output reg         WB_EN_OUT,
  output reg  [4:0]  WB_IDX_OUT,
  output reg  [31:0] WB_DATA_OUT,
  output reg         BUS_READ_OUT,
  output reg  [31:0] BUS_ADDR_OUT,
  output reg  [3:0]  BUS_BYTEEN_OUT,
  input  wire        BUS_WAIT_IN,
  input  wire        BUS_RDVALID_IN,
  input  wire [31:0] BUS_RDATA_IN,
  output reg         CACHE_LOOKUP_OUT,
  output reg  [31:0] CACHE_ADDR_OUT,
  input  wire        CACHE_HIT_IN,
  input  wire [31:0] CACHE_RDATA_IN
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [31:0] sext16;
    input [15:0] v;
    begin
      sext16 = {{16{v[15]}}, v};
    end
  endfunction

  // Zero register always reads as zero
  function [31:0] src_val;
    input [4:0]  idx;
    input [31:0] data;
    begin
      src_val = (idx == `LDM_ZERO_IDX) ? `LDM_ZERO_WORD : data;
    end
  endfunction

  function [3:0] byte_enables;
    input [1:0] size;
    input [1:0] lane;
    begin
      case (size)
        `LDM_SZ_BYTE: byte_enables = `LDM_BE_BYTE << lane;
        `LDM_SZ_HALF: byte_enables = `LDM_BE_HALF << {lane[1], 1'b0};
        default:      byte_enables = `LDM_BE_WORD;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  wire [4:0]  first_source_index;
  wire [4:0]  second_operand_index;
  wire [4:0]  third_operand_index;
  wire [15:0] sixteen_bit_offset;
  wire [5:0]  opcode;
  wire [5:0]  ext_opcode;
  wire [31:0] src_a;
  wire [31:0] src_b;
  wire [31:0] eff_addr;

  assign first_source_index   = INSTR_IN[`LDM_FLD_A_HI:`LDM_FLD_A_LO];     // see (RULE20)
  assign second_operand_index = INSTR_IN[`LDM_FLD_B_HI:`LDM_FLD_B_LO];     // see (RULE20)
  assign sixteen_bit_offset   = INSTR_IN[`LDM_FLD_IMM_HI:`LDM_FLD_IMM_LO]; // see (RULE15)
  assign opcode               = INSTR_IN[`LDM_FLD_OP_HI:`LDM_FLD_OP_LO];   // see (RULE20)
  assign third_operand_index  = INSTR_IN[`LDM_FLD_C_HI:`LDM_FLD_C_LO];
  assign ext_opcode           = INSTR_IN[`LDM_FLD_OPX_HI:`LDM_FLD_OPX_LO];
  assign src_a                = src_val(first_source_index, SRC_A_DATA_IN);
  assign src_b                = src_val(second_operand_index, SRC_B_DATA_IN);

  ldm_agen u_agen (
    .base_in               (src_a),
    .sixteen_bit_offset_in (sixteen_bit_offset),
    .addr_out              (eff_addr)
  );

  // ----------------------------------------------------------------
  // Load decode
  // ----------------------------------------------------------------
  reg        dec_load;
  reg        dec_io;
  reg [1:0]  dec_size;
  reg        dec_signed;

  always @* begin
    dec_load   = 1'b1;
    dec_io     = 1'b0;
    dec_size   = `LDM_SZ_WORD;
    dec_signed = 1'b0;
    case (opcode)
      `LDM_OP_LDBU:   dec_size = `LDM_SZ_BYTE; // see (RULE1)
      `LDM_OP_LDBUIO: begin
        dec_size = `LDM_SZ_BYTE; // see (RULE1)
        dec_io   = 1'b1;
      end
      `LDM_OP_LDH: begin
        dec_size   = `LDM_SZ_HALF; // see (RULE12)
        dec_signed = 1'b1;
      end
      `LDM_OP_LDHIO: begin
        dec_size   = `LDM_SZ_HALF; // see (RULE12)
        dec_signed = 1'b1;
        dec_io     = 1'b1;
      end
      `LDM_OP_LDHU:   dec_size = `LDM_SZ_HALF; // see (RULE13)
      `LDM_OP_LDHUIO: begin
        dec_size = `LDM_SZ_HALF; // see (RULE13)
        dec_io   = 1'b1;
      end
      `LDM_OP_LDW:    dec_size = `LDM_SZ_WORD; // see (RULE14)
      `LDM_OP_LDWIO: begin
        dec_size = `LDM_SZ_WORD; // see (RULE14)
        dec_io   = 1'b1;
      end
      default:        dec_load = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Move-form arithmetic and logic decode
  // ----------------------------------------------------------------
  reg        dec_alu;
  reg [4:0]  alu_dest;
  reg [31:0] alu_result;

  always @* begin
    dec_alu    = 1'b1;
    alu_dest   = second_operand_index;
    alu_result = `LDM_ZERO_WORD;
    if (opcode == OP_ADDI) begin
      alu_result = src_a + sext16(sixteen_bit_offset); // see (RULE17)
    end else if (opcode == OP_ORI) begin
      alu_result = src_a | {`LDM_ZERO_HALF, sixteen_bit_offset};
    end else if (opcode == OP_ORHI) begin
      alu_result = src_a | {sixteen_bit_offset, `LDM_ZERO_HALF}; // see (RULE16)
    end else if (opcode == OP_RTYPE && ext_opcode == OPX_ADD) begin
      alu_dest   = third_operand_index;
      alu_result = src_a + src_b; // see (RULE18)
    end else begin
      dec_alu = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Load data extension
  // ----------------------------------------------------------------
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [1:0]  size_r;
  reg         signed_r;
  reg  [1:0]  lane_r;
  reg  [4:0]  dest_r;
  wire [31:0] ret_word;
  wire [31:0] ret_value;

  assign ret_word = (state_r == `LDM_ST_CACHE) ? CACHE_RDATA_IN : BUS_RDATA_IN;

  ldm_extend u_extend (
    .word_in   (ret_word),
    .lane_in   (lane_r),
    .size_in   (size_r),
    .signed_in (signed_r),
    .value_out (ret_value)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wire accept;
  wire use_cache;

  assign accept    = INSTR_VALID_IN && INSTR_READY_OUT;
  // I/O loads and cacheless cores go to the bus
  assign use_cache = (HAS_DCACHE != 0) && !dec_io; // see (RULE9) (RULE10) (RULE11)

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `LDM_ST_IDLE: begin
        if (accept && dec_load) begin
          state_nxt = use_cache ? `LDM_ST_CACHE : `LDM_ST_BUS_REQ;
        end else if (accept && dec_alu) begin
          state_nxt = `LDM_ST_WB;
        end
      end
      `LDM_ST_CACHE:    state_nxt = CACHE_HIT_IN ? `LDM_ST_WB : `LDM_ST_BUS_REQ; // see (RULE9)
      `LDM_ST_BUS_REQ:  state_nxt = BUS_WAIT_IN ? `LDM_ST_BUS_REQ : `LDM_ST_BUS_WAIT;
      `LDM_ST_BUS_WAIT: state_nxt = BUS_RDVALID_IN ? `LDM_ST_WB : `LDM_ST_BUS_WAIT;
      `LDM_ST_WB:       state_nxt = `LDM_ST_IDLE;
      default:          state_nxt = `LDM_ST_IDLE;
    endcase
  end

  always @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      state_r          <= `LDM_ST_IDLE;
      size_r           <= `LDM_SZ_WORD;
      signed_r         <= 1'b0;
      lane_r           <= 2'h0;
      dest_r           <= `LDM_ZERO_IDX;
      INSTR_READY_OUT  <= 1'b0;
      UNHANDLED_OUT    <= 1'b0;
      WB_EN_OUT        <= 1'b0;
      WB_IDX_OUT       <= `LDM_ZERO_IDX;
      WB_DATA_OUT      <= `LDM_ZERO_WORD;
      BUS_READ_OUT     <= 1'b0;
      BUS_ADDR_OUT     <= `LDM_ZERO_WORD;
      BUS_BYTEEN_OUT   <= 4'h0;
      CACHE_LOOKUP_OUT <= 1'b0;
      CACHE_ADDR_OUT   <= `LDM_ZERO_WORD;
    end else begin
      state_r          <= state_nxt;
      INSTR_READY_OUT  <= (state_nxt == `LDM_ST_IDLE);
      UNHANDLED_OUT    <= accept && !dec_load && !dec_alu;
      WB_EN_OUT        <= 1'b0;
      CACHE_LOOKUP_OUT <= 1'b0;
      case (state_r)
        `LDM_ST_IDLE: begin
          if (accept && dec_load) begin
            size_r         <= dec_size;
            signed_r       <= dec_signed;
            lane_r         <= eff_addr[1:0];
            dest_r         <= second_operand_index; // see (RULE15)
            BUS_ADDR_OUT   <= eff_addr; // see (RULE3)
            CACHE_ADDR_OUT <= eff_addr;
            BUS_BYTEEN_OUT <= byte_enables(dec_size, eff_addr[1:0]);
            if (use_cache) begin
              CACHE_LOOKUP_OUT <= 1'b1; // see (RULE9)
            end else begin
              BUS_READ_OUT <= 1'b1; // see (RULE10) (RULE11)
            end
          end else if (accept && dec_alu) begin
            dest_r      <= alu_dest;
            WB_IDX_OUT  <= alu_dest;
            WB_DATA_OUT <= alu_result; // see (RULE16) (RULE17) (RULE18)
            // Zero register is never written
            WB_EN_OUT   <= (alu_dest != `LDM_ZERO_IDX);
          end
        end
        `LDM_ST_CACHE: begin
          if (CACHE_HIT_IN) begin
            WB_IDX_OUT  <= dest_r;
            WB_DATA_OUT <= ret_value; // see (RULE2) (RULE4) (RULE5) (RULE8)
            WB_EN_OUT   <= (dest_r != `LDM_ZERO_IDX);
          end else begin
            BUS_READ_OUT <= 1'b1;
          end
        end
        `LDM_ST_BUS_REQ: begin
          if (!BUS_WAIT_IN) begin
            BUS_READ_OUT <= 1'b0;
          end
        end
        `LDM_ST_BUS_WAIT: begin
          if (BUS_RDVALID_IN) begin
            WB_IDX_OUT  <= dest_r;
            WB_DATA_OUT <= ret_value; // see (RULE2) (RULE4) (RULE5) (RULE8)
            WB_EN_OUT   <= (dest_r != `LDM_ZERO_IDX);
          end
        end
        `LDM_ST_WB: begin
          BUS_READ_OUT <= 1'b0;
        end
        default: begin
          BUS_READ_OUT <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** src/ldm_regs.vh ***
// Constants for the load and move decode block: field positions,
// opcodes, access sizes and state codes.
// Assumes inclusion by bare name from the design files.
`ifndef LDM_REGS_VH
`define LDM_REGS_VH

// ----------------------------------------------------------------
// Immediate-type instruction fields
// ----------------------------------------------------------------
`define LDM_FLD_A_HI        31
`define LDM_FLD_A_LO        27
`define LDM_FLD_B_HI        26
`define LDM_FLD_B_LO        22
`define LDM_FLD_IMM_HI      21
`define LDM_FLD_IMM_LO      6
`define LDM_FLD_OP_HI       5
`define LDM_FLD_OP_LO       0

// ----------------------------------------------------------------
// Register-type instruction fields
// ----------------------------------------------------------------
`define LDM_FLD_C_HI        21
`define LDM_FLD_C_LO        17
`define LDM_FLD_OPX_HI      16
`define LDM_FLD_OPX_LO      11

// ----------------------------------------------------------------
// Load opcodes
// ----------------------------------------------------------------
`define LDM_OP_LDBU         6'h03
`define LDM_OP_LDBUIO       6'h23
`define LDM_OP_LDH          6'h0F
`define LDM_OP_LDHIO        6'h2F
`define LDM_OP_LDHU         6'h0B
`define LDM_OP_LDHUIO       6'h2B
`define LDM_OP_LDW          6'h17
`define LDM_OP_LDWIO        6'h37

// ----------------------------------------------------------------
// Arithmetic and logic opcodes behind the move forms (defaults)
// ----------------------------------------------------------------
`define LDM_OP_ADDI_DEF     6'h04
`define LDM_OP_ORI_DEF      6'h0C
`define LDM_OP_ORHI_DEF     6'h1C
`define LDM_OP_RTYPE_DEF    6'h3A
`define LDM_OPX_ADD_DEF     6'h31

// ----------------------------------------------------------------
// Access sizes
// ----------------------------------------------------------------
`define LDM_SZ_BYTE         2'h0
`define LDM_SZ_HALF         2'h1
`define LDM_SZ_WORD         2'h2

// ----------------------------------------------------------------
// Byte enables and misc
// ----------------------------------------------------------------
`define LDM_BE_BYTE         4'h1
`define LDM_BE_HALF         4'h3
`define LDM_BE_WORD         4'hF
`define LDM_ZERO_IDX        5'h00
`define LDM_ZERO_WORD       32'h0000_0000
`define LDM_ZERO_HALF       16'h0000

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
`define LDM_ST_IDLE         3'h0
`define LDM_ST_CACHE        3'h1
`define LDM_ST_BUS_REQ      3'h2
`define LDM_ST_BUS_WAIT     3'h3
`define LDM_ST_WB           3'h4

`endif

// *** src/ldm_agen.v ***
// Effective address adder for loads.
// Assumes base register value and raw offset field from the same clock.
`timescale 1ns/1ns
module ldm_agen (
  input  wire [31:0] base_in,
  input  wire [15:0] sixteen_bit_offset_in,
  output wire [31:0] addr_out
);

  // ----------------------------------------------------------------
  // Base plus sign-extended offset
  // ----------------------------------------------------------------
  assign addr_out = base_in + {{16{sixteen_bit_offset_in[15]}}, sixteen_bit_offset_in}; // see (RULE3)

endmodule

// *** src/ldm_extend.v ***
// Lane select and extension of returned load data.
// Assumes little-endian lanes on a 32-bit data path.
`include "ldm_regs.vh"
`timescale 1ns/1ns
module ldm_extend (
  input  wire [31:0] word_in,
  input  wire [1:0]  lane_in,
  input  wire [1:0]  size_in,
  input  wire        signed_in,
  output reg  [31:0] value_out
);

  reg [7:0]  byte_sel;
  reg [15:0] half_sel;

  // ----------------------------------------------------------------
  // Pick lane, then extend
  // ----------------------------------------------------------------
  always @* begin
    byte_sel = word_in[{lane_in, 3'h0} +: 8];
    half_sel = lane_in[1] ? word_in[31:16] : word_in[15:0];
    case (size_in)
      `LDM_SZ_BYTE: value_out = {24'h00_0000, byte_sel}; // see (RULE2)
      `LDM_SZ_HALF: begin
        if (signed_in) begin
          value_out = {{16{half_sel[15]}}, half_sel}; // see (RULE4)
        end else begin
          value_out = {`LDM_ZERO_HALF, half_sel}; // see (RULE5)
        end
      end
      `LDM_SZ_WORD: value_out = word_in; // see (RULE8)
      default:      value_out = word_in;
    endcase
  end

endmodule

// *** testbench/ldm_properties.sv ***
// Checker for the load and move unit, bound to its top module.
// Assumes the default move-form opcodes and a slave that keeps one read outstanding.
`timescale 1ns/1ns
module ldm_properties #(
  parameter HAS_DCACHE = 1
) (
  input logic        CORE_CLK_IN,
  input logic        SRST_IN,
  input logic [31:0] INSTR_IN,
  input logic        INSTR_VALID_IN,
  input logic [31:0] SRC_A_DATA_IN,
  input logic        INSTR_READY_OUT,
  input logic        WB_EN_OUT,
  input logic [4:0]  WB_IDX_OUT,
  input logic [31:0] WB_DATA_OUT,
  input logic        BUS_READ_OUT,
  input logic [31:0] BUS_ADDR_OUT,
  input logic [3:0]  BUS_BYTEEN_OUT,
  input logic        BUS_WAIT_IN,
  input logic        BUS_RDVALID_IN,
  input logic [31:0] BUS_RDATA_IN,
  input logic        CACHE_LOOKUP_OUT,
  input logic [31:0] CACHE_ADDR_OUT,
  input logic        CACHE_HIT_IN
);
  wire [5:0]  op = INSTR_IN[5:0];
  wire        tk = INSTR_VALID_IN && INSTR_READY_OUT;
  wire [31:0] sa = (INSTR_IN[31:27] == 5'h00) ? 32'h0000_0000 : SRC_A_DATA_IN;
  wire [31:0] ea = sa + {{16{INSTR_IN[21]}}, INSTR_IN[21:6]};
  wire [31:0] hi = sa | {INSTR_IN[21:6], 16'h0000};
  wire [4:0]  b  = INSTR_IN[26:22];
  wire [4:0]  c  = INSTR_IN[21:17];
  wire        io = op == 6'h23 || op == 6'h2F || op == 6'h2B || op == 6'h37;
  wire        cl = op == 6'h03 || op == 6'h0F || op == 6'h0B || op == 6'h17;
  reg  [5:0]  op_r;
  reg  [4:0]  b_r;
  reg         pend_r;
  // Remembers the load in flight
  always @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      op_r   <= 6'h00;
      b_r    <= 5'h00;
      pend_r <= 1'b0;
    end else if (tk) begin
      op_r   <= op;
      b_r    <= b;
      pend_r <= io || cl;
    end else if (WB_EN_OUT) begin
      pend_r <= 1'b0;
    end
  end
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);
  sequence s_take_io; tk && (io || (cl && HAS_DCACHE == 0)); endsequence
  sequence s_take_ld; tk && cl && HAS_DCACHE != 0; endsequence
  sequence s_data; BUS_RDVALID_IN && pend_r && b_r != 5'h00; endsequence
  io_bus_read_a : assert property (
    s_take_io |=> BUS_READ_OUT && !CACHE_LOOKUP_OUT && BUS_ADDR_OUT == $past(ea))
    else $error("io load missed the bus");
  cache_addr_a : assert property (
    s_take_ld |=> CACHE_LOOKUP_OUT && CACHE_ADDR_OUT == $past(ea)) else $error("bad cache lookup");
  miss_read_a : assert property (
    CACHE_LOOKUP_OUT && !CACHE_HIT_IN |=> BUS_READ_OUT && BUS_ADDR_OUT == $past(CACHE_ADDR_OUT))
    else $error("miss without bus read");
  hit_no_read_a : assert property (
    CACHE_LOOKUP_OUT && CACHE_HIT_IN && b_r != 5'h00 |=> WB_EN_OUT && !BUS_READ_OUT)
    else $error("hit not answered");
  read_hold_a : assert property (
    BUS_READ_OUT && BUS_WAIT_IN |=> BUS_READ_OUT && $stable(BUS_ADDR_OUT) && $stable(BUS_BYTEEN_OUT))
    else $error("read dropped in wait");
  word_data_a : assert property (
    s_data ##0 op_r[4:0] == 5'h17 |=> WB_EN_OUT && WB_DATA_OUT == $past(BUS_RDATA_IN))
    else $error("word load altered");
  byte_zero_a : assert property (
    s_data ##0 op_r[4:0] == 5'h03 |=> WB_EN_OUT && WB_DATA_OUT[31:8] == 24'h000000)
    else $error("byte not zero extended");
  half_sign_a : assert property (
    s_data ##0 op_r[4:0] == 5'h0F |=> WB_EN_OUT && WB_DATA_OUT[31:16] == {16{WB_DATA_OUT[15]}})
    else $error("half not sign extended");
  half_zero_a : assert property (
    s_data ##0 op_r[4:0] == 5'h0B |=> WB_EN_OUT && WB_DATA_OUT[31:16] == 16'h0000)
    else $error("half not zero extended");
  small_const_a : assert property (
    tk && op == 6'h04 && b != 5'h00 |=> WB_EN_OUT && WB_IDX_OUT == $past(b) && WB_DATA_OUT == $past(ea))
    else $error("add immediate wrong");
  high_const_a : assert property (
    tk && op == 6'h1C && b != 5'h00 |=> WB_EN_OUT && WB_DATA_OUT == $past(hi)) else $error("high or wrong");
  reg_copy_a : assert property (
    tk && op == 6'h3A && INSTR_IN[16:11] == 6'h31 && b == 5'h00 && c != 5'h00
    |=> WB_EN_OUT && WB_IDX_OUT == $past(c) && WB_DATA_OUT == $past(sa)) else $error("copy wrong");
endmodule

bind ldm_core ldm_properties #(.HAS_DCACHE(HAS_DCACHE)) u_props (.CORE_CLK_IN, .SRST_IN, .INSTR_IN,
  .INSTR_VALID_IN, .SRC_A_DATA_IN, .INSTR_READY_OUT, .WB_EN_OUT, .WB_IDX_OUT, .WB_DATA_OUT, .BUS_READ_OUT,
  .BUS_ADDR_OUT, .BUS_BYTEEN_OUT, .BUS_WAIT_IN, .BUS_RDVALID_IN, .BUS_RDATA_IN, .CACHE_LOOKUP_OUT,
  .CACHE_ADDR_OUT, .CACHE_HIT_IN);

// *** testbench/ldm_bus_model.sv ***
// Data bus slave holding a patterned memory, with set wait and latency.
// Assumes one read outstanding at a time.
`timescale 1ns/1ns
module ldm_bus_model (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        read_in,
  input  wire [31:0] addr_in,
  input  wire [3:0]  wait_cfg_in,
  input  wire [3:0]  lat_cfg_in,
  output wire        wait_out,
  output reg         rdvalid_out,
  output reg  [31:0] rdata_out,
  output reg  [7:0]  reads_out
);
  reg [3:0]  wc_r;
  reg [3:0]  dc_r;
  reg        busy_r;
  reg [31:0] a_r;
  assign wait_out = read_in && wc_r != wait_cfg_in;
  always @(posedge clk_in) begin
    rdvalid_out <= 1'b0;
    // Data lines change every cycle outside the valid pulse and reset
    rdata_out   <= ~rdata_out;
    if (rst_in) begin
      wc_r      <= 4'h0;
      busy_r    <= 1'b0;
      reads_out <= 8'h00;
      rdata_out <= 32'h0000_0000;
    end else if (read_in && !wait_out) begin
      wc_r      <= 4'h0;
      busy_r    <= 1'b1;
      dc_r      <= lat_cfg_in;
      a_r       <= addr_in;
      reads_out <= reads_out + 8'h01;
    end else begin
      if (read_in)
        wc_r <= wc_r + 4'h1;
      if (busy_r && dc_r == 4'h0) begin
        rdvalid_out <= 1'b1;
        rdata_out   <= {a_r[15:2], 2'h0, ~a_r[15:2], 2'h3};
        busy_r      <= 1'b0;
      end else if (busy_r) begin
        dc_r <= dc_r - 4'h1;
      end
    end
  end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the load and move unit.
// Assumes the bus model memory pattern and default move-form opcodes.
`timescale 1ns/1ns
module testbench;
  reg         clk   = 1'b0;
  reg         rst   = 1'b1;
  reg  [31:0] instr = 32'h0000_0000;
  reg         vld   = 1'b0;
  reg  [31:0] src_a = 32'h0000_0000;
  reg         hit   = 1'b0;
  reg  [31:0] cdata = 32'h0000_0000;
  reg  [3:0]  wcfg  = 4'h0;
  reg  [3:0]  lcfg  = 4'h0;
  wire        rdy, unh, wb_en, rd, wt, rv, lk;
  wire [4:0]  wb_idx;
  wire [31:0] wb_d, ba, rdat, ca;
  wire [3:0]  be;
  wire [7:0]  nrd;
  wire        nc_rd, nc_wt, nc_rv;
  wire [31:0] nc_d, nc_ba, nc_rdat;
  integer     bad_count   = 0;
  integer     comparisons = 0;
  always #20 clk = ~clk;
  ldm_core dut (.CORE_CLK_IN(clk), .SRST_IN(rst), .INSTR_IN(instr), .INSTR_VALID_IN(vld), .SRC_A_DATA_IN(src_a),
    .SRC_B_DATA_IN(32'hDEAD_BEEF), .INSTR_READY_OUT(rdy), .UNHANDLED_OUT(unh), .WB_EN_OUT(wb_en),
    .WB_IDX_OUT(wb_idx), .WB_DATA_OUT(wb_d), .BUS_READ_OUT(rd), .BUS_ADDR_OUT(ba), .BUS_BYTEEN_OUT(be),
    .BUS_WAIT_IN(wt), .BUS_RDVALID_IN(rv), .BUS_RDATA_IN(rdat), .CACHE_LOOKUP_OUT(lk), .CACHE_ADDR_OUT(ca),
    .CACHE_HIT_IN(hit), .CACHE_RDATA_IN(cdata));
  ldm_bus_model mem (.clk_in(clk), .rst_in(rst), .read_in(rd), .addr_in(ba), .wait_cfg_in(wcfg),
    .lat_cfg_in(lcfg), .wait_out(wt), .rdvalid_out(rv), .rdata_out(rdat), .reads_out(nrd));
  ldm_core #(.HAS_DCACHE(0)) dut_nc (.CORE_CLK_IN(clk), .SRST_IN(rst), .INSTR_IN(instr), .INSTR_VALID_IN(vld),
    .SRC_A_DATA_IN(src_a), .SRC_B_DATA_IN(32'hDEAD_BEEF), .INSTR_READY_OUT(), .UNHANDLED_OUT(), .WB_EN_OUT(),
    .WB_IDX_OUT(), .WB_DATA_OUT(nc_d), .BUS_READ_OUT(nc_rd), .BUS_ADDR_OUT(nc_ba), .BUS_BYTEEN_OUT(),
    .BUS_WAIT_IN(nc_wt), .BUS_RDVALID_IN(nc_rv), .BUS_RDATA_IN(nc_rdat), .CACHE_LOOKUP_OUT(), .CACHE_ADDR_OUT(),
    .CACHE_HIT_IN(hit), .CACHE_RDATA_IN(cdata));
  ldm_bus_model mem_nc (.clk_in(clk), .rst_in(rst), .read_in(nc_rd), .addr_in(nc_ba), .wait_cfg_in(wcfg),
    .lat_cfg_in(lcfg), .wait_out(nc_wt), .rdvalid_out(nc_rv), .rdata_out(nc_rdat), .reads_out());
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] ins(input [4:0] a, input [4:0] b, input [15:0] im, input [5:0] op);
    ins = {a, b, im, op};
  endfunction
  function [31:0] ext(input [5:0] op, input [31:0] w, input [1:0] ln);
    reg [31:0] s;
    begin
      s = w >> (ln * 8);
      case (op[4:0])
        5'h03: ext = {24'h000000, s[7:0]};
        5'h0F: ext = {{16{s[15]}}, s[15:0]};
        5'h0B: ext = {16'h0000, s[15:0]};
        default: ext = w;
      endcase
    end
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Offers one instruction, then collects its write or unhandled pulse
  task run(input [31:0] i, input [31:0] a, output [31:0] d, output [4:0] ix, output e, output u);
    integer n;
    e = 1'b0;
    u = 1'b0;
    d = 32'h0000_0000;
    ix = 5'h00;
    @(posedge clk);
    instr <= i;
    src_a <= a;
    vld <= 1'b1;
    @(negedge clk);
    for (n = 0; n < 50 && rdy !== 1'b1; n = n + 1)
      @(negedge clk);
    @(posedge clk);
    vld <= 1'b0;
    for (n = 0; n < 40 && !e; n = n + 1) begin
      @(negedge clk);
      if (wb_en === 1'b1) begin
        e = 1'b1;
        d = wb_d;
        ix = wb_idx;
      end
      if (unh === 1'b1)
        u = 1'b1;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_loads;
    localparam [47:0]  OPS = {6'h03, 6'h23, 6'h0F, 6'h2F, 6'h0B, 6'h2B, 6'h17, 6'h37};
    localparam [127:0] OFS = {16'h0005, 16'hFFFD, 16'h0002, 16'hFFFC, 16'h0000, 16'h0006, 16'h0008, 16'hFFF8};
    integer k;
    reg [5:0] op;
    reg [15:0] of;
    reg [31:0] a, d;
    reg [4:0] ix;
    reg e, u;
    reg [7:0] n0;
    for (k = 0; k < 8; k = k + 1) begin
      op = OPS[47-6*k -: 6];
      of = OFS[127-16*k -: 16];
      a = 32'h0000_1000 + {{16{of[15]}}, of};
      wcfg = k % 3;
      lcfg = k % 2;
      n0 = nrd;
      run(ins(5'h03, 5'h06, of, op), 32'h0000_1000, d, ix, e, u);
      check(d, ext(op, {a[15:2], 2'h0, ~a[15:2], 2'h3}, a[1:0]));
      check({26'h0, e, ix}, {26'h0, 1'b1, 5'h06});
      check({24'h0, nrd - n0}, 32'h0000_0001);
      check({28'h0, be}, op[4:0] == 5'h03 ? 32'h1 << a[1:0] :
        op[4:0] == 5'h17 ? 32'hF : 32'h3 << {a[1], 1'b0});
      check(nc_d, ext(op, {a[15:2], 2'h0, ~a[15:2], 2'h3}, a[1:0]));
    end
  endtask
  task t_cache;
    reg [31:0] d;
    reg [4:0] ix;
    reg e, u;
    reg [7:0] n0;
    @(posedge clk);
    hit <= 1'b1;
    cdata <= 32'h8765_4321;
    n0 = nrd;
    run(ins(5'h03, 5'h07, 16'h0000, 6'h17), 32'h0000_2000, d, ix, e, u);
    check(d, 32'h8765_4321);
    run(ins(5'h03, 5'h07, 16'h0003, 6'h03), 32'h0000_2000, d, ix, e, u);
    check(d, 32'h0000_0087);
    check({24'h0, nrd - n0}, 32'h0000_0000);
    run(ins(5'h03, 5'h07, 16'h0000, 6'h37), 32'h0000_2000, d, ix, e, u);
    check(d, {14'h0800, 2'h0, ~14'h0800, 2'h3});
    check({24'h0, nrd - n0}, 32'h0000_0001);
    @(posedge clk);
    hit <= 1'b0;
  endtask
  task t_moves;
    integer k;
    reg [15:0] im;
    reg [5:0] op;
    reg [31:0] x, d;
    reg [4:0] ix;
    reg e, u;
    for (k = 0; k < 5; k = k + 1) begin
      case (k)
        0: begin im = 16'hFFE2; op = 6'h04; x = 32'hFFFF_FFE2; end
        1: begin im = 16'h7FFF; op = 6'h04; x = 32'h0000_7FFF; end
        2: begin im = 16'h8000; op = 6'h04; x = 32'hFFFF_8000; end
        3: begin im = 16'hFFFF; op = 6'h1C; x = 32'hFFFF_0000; end
        default: begin im = 16'hFFFF; op = 6'h0C; x = 32'h0000_FFFF; end
      endcase
      run(ins(5'h00, 5'h06, im, op), 32'h5555_5555, d, ix, e, u);
      check(d, x);
    end
    run({5'h07, 5'h00, 5'h06, 6'h31, 5'h00, 6'h3A}, 32'hCAFE_0123, d, ix, e, u);
    check(d, 32'hCAFE_0123);
    check({27'h0, ix}, 32'h0000_0006);
    run(ins(5'h00, 5'h06, 16'h1235, 6'h1C), 32'h0000_0000, d, ix, e, u);
    run(ins(5'h06, 5'h06, 16'h9ABC, 6'h04), d, d, ix, e, u);
    check(d, 32'h1234_9ABC);
  endtask
  task t_unh;
    reg [31:0] d;
    reg [4:0] ix;
    reg e, u;
    reg [7:0] n0;
    n0 = nrd;
    run(ins(5'h03, 5'h06, 16'h0000, 6'h3F), 32'h0000_1000, d, ix, e, u);
    check({30'h0, e, u}, 32'h0000_0001);
    check({24'h0, nrd - n0}, 32'h0000_0000);
  endtask
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_loads;
    t_cache;
    t_moves;
    t_unh;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count = bad_count + 1;
    $display("MISMATCH %0t watchdog expired", $time);
    finish_test;
  end
endmodule
